// File: hw/crd_pkg.sv
// crd_pkg: constants for the cache and TLB debug readout block.
// assumes one core clock; raw entry layouts are those of the array port.
package crd_pkg;

   // ----------------------------------------------------------------
   // selection word
   // ----------------------------------------------------------------
   localparam int SEL_CODE_LSB = 24;
   localparam int SEL_WAY_LSB = 18;
   localparam int SEL_COPY_BIT = 17;
   localparam int SEL_BANK_LSB = 16;
   localparam logic [7:0] CODE_GHB = 8'h03;
   localparam logic [7:0] CODE_ITLB = 8'h04;
   localparam logic [7:0] CODE_BRANCH_PREDICTION_QUEUE = 8'h05;
   localparam logic [7:0] CODE_DTAG = 8'h08;
   localparam logic [7:0] CODE_DDATA = 8'h09;
   localparam logic [7:0] CODE_DTLB = 8'h0A;
   // location bits kept per array, reserved bits cleared
   localparam logic [23:0] KEEP_DTAG = 24'h0E3FC0;
   localparam logic [23:0] KEEP_DDATA = 24'h0F3FC0;
   localparam logic [23:0] KEEP_DTLB = 24'h00003F;
   localparam logic [23:0] KEEP_ITLB = 24'h0000FF;
   localparam logic [23:0] KEEP_BRANCH_PREDICTION_QUEUE = 24'h0003F0;
   localparam logic [23:0] KEEP_GHB = 24'h003FF0;
   localparam logic [7:0] TLB_ENTRIES = 8'h30;

   // ----------------------------------------------------------------
   // system register numbers and privilege
   // ----------------------------------------------------------------
   localparam logic [2:0] REG_IDATA0 = 3'h0;
   localparam logic [2:0] REG_IDATA1 = 3'h1;
   localparam logic [2:0] REG_IDATA2 = 3'h2;
   localparam logic [2:0] REG_DDATA0 = 3'h3;
   localparam logic [2:0] REG_DDATA1 = 3'h4;
   localparam logic [2:0] REG_DDATA2 = 3'h5;
   localparam logic [1:0] EL_TOP = 2'h3;
   localparam logic [63:0] READOUT_RESET = 64'h0;
   localparam logic [31:0] SELECT_RESET = 32'h0;

   // ----------------------------------------------------------------
   // raw entry layout on the array port
   // ----------------------------------------------------------------
   localparam int RAW_W = 160;
   localparam int DT_R_STATE = 0;
   localparam int DT_R_HINT = 2;
   localparam int DT_R_PA = 3;
   localparam int DT_R_NS = 39;
   localparam int DT_R_ECC = 40;
   localparam int DD_R_CHK = 128;
   localparam int TL_R_VA = 0;
   localparam int TL_R_OSH = 2;
   localparam int TL_R_ISH = 3;
   localparam int TL_R_ATTR = 4;
   localparam int TL_R_SIZE = 7;
   localparam int TL_R_NS = 10;
   localparam int TL_R_REGIME = 11;
   localparam int TL_R_ASID = 13;
   localparam int TL_R_VMID = 29;
   localparam int TL_R_VALID = 45;
   localparam int TL_R_PALO = 46;
   localparam int TL_R_VAHI = 75;
   localparam int TL_R_PAHI = 110;
   localparam int TL_R_PAGE_HW_ATTRIBUTE = 117;
   localparam int IT_R_VA = 0;
   localparam int IT_R_PAGE_HW_ATTRIBUTE = 5;
   localparam int IT_R_ATTR = 7;
   localparam int IT_R_SIZE = 10;
   localparam int IT_R_PALO = 13;
   localparam int IT_R_VAHI = 45;
   localparam int IT_R_NS = 77;
   localparam int IT_R_PAHI = 78;

   // ----------------------------------------------------------------
   // readout field positions
   // ----------------------------------------------------------------
   localparam int DT_O_STATE = 0;
   localparam int DT_O_HINT = 2;
   localparam int DT_O_PA = 5;
   localparam int DT_O_NS = 41;
   localparam int DT_O_ECC = 42;
   localparam int TL_O_VALID = 0;
   localparam int TL_O_VMID = 1;
   localparam int TL_O_ASID = 17;
   localparam int TL_O_REGIME = 33;
   localparam int TL_O_NS = 35;
   localparam int TL_O_SIZE = 36;
   localparam int TL_O_ATTR = 50;
   localparam int TL_O_ISH = 57;
   localparam int TL_O_OSH = 58;
   localparam int TL_O_VA = 62;
   localparam int TL_O_PALO = 35;
   localparam int TL_O_PAGE_HW_ATTRIBUTE = 7;
   localparam int IT_O_SIZE = 50;
   localparam int IT_O_ATTR = 53;
   localparam int IT_O_PAGE_HW_ATTRIBUTE = 57;
   localparam int IT_O_VA = 59;
   localparam int IT_O_PALO = 32;
   localparam int IT_O_NS = 4;

   typedef enum logic [1:0] {
      CRD_IDLE = 2'b00,
      CRD_REQ = 2'b01,
      CRD_WAIT = 2'b10
   } crd_state_e;

endpackage

// File: hw/crd_readout.sv
// crd_readout: privileged debug readout of L1 data cache, TLB and
// branch predictor arrays into six 64-bit read-only registers.
// assumes the array port answers every request exactly once.
//
// Functional notes
// RULE_01 - select write and reads only at top level
// RULE_02 - six read-only readout registers, instruction and data
// RULE_03 - selector bits 31:24 pick tag, data, TLB
// RULE_04 - data cache treated as four-way set associative
// RULE_05 - tag read bit 17 picks pipe copy
// RULE_06 - data read bits 17:16 pick doubleword bank
// RULE_07 - data TLB entry in bits 5:0, 0-47
// RULE_08 - tag readout: ECC, non-secure, physical address
// RULE_09 - tag readout: hint bit 2, coherence state
// RULE_10 - data readout: words 1:0 then 3:2
// RULE_11 - data register 2 holds poison and ECC
// RULE_12 - memory attributes as three-bit code
// RULE_13 - data TLB register 0 upper fields
// RULE_14 - data TLB register 0 ASID, VMID, valid
// RULE_15 - data TLB registers 1 and 2 addresses
// RULE_16 - instruction TLB register 0 fields
// RULE_17 - instruction TLB registers 1 and 2
// RULE_18 - queue entry split across registers 0, 2
// RULE_19 - history buffer entry split registers 0, 1
// RULE_20 - reserved select bits ignored, unused bits zero
// RULE_21 - software waits for fetch before reading
`timescale 1ns/1ps
`default_nettype none

module crd_readout
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // build options
   input wire logic cache_protect_present,
   input wire logic page_attr_build_option,
   // system register access
   input wire logic sys_req_valid,
   input wire logic sys_req_write,
   input wire logic [2:0] sys_req_reg,
   input wire logic [1:0] sys_req_el,
   input wire logic [31:0] sys_req_wdata,
   output logic sys_rsp_valid,
   output logic sys_rsp_undef,
   output logic [63:0] sys_rsp_rdata,
   output logic sel_busy,
   // array fetch port
   output logic arr_req_valid,
   output logic [7:0] arr_req_code,
   output logic [1:0] arr_req_way,
   output logic arr_req_copy,
   output logic [1:0] arr_req_bank,
   output logic [23:0] arr_req_loc,
   input wire logic arr_rsp_valid,
   input wire logic [crd_pkg::RAW_W-1:0] arr_rsp_data
);

   crd_pkg::crd_state_e state_q;
   logic [31:0] select_q;
   logic [63:0] idata_q [3];
   logic [63:0] ddata_q [3];
   logic [63:0] ipack [3];
   logic [63:0] dpack [3];
   logic protect_q;
   logic page_hw_attribute_opt_q;
   logic priv_ok;
   logic take_write;
   logic [7:0] code;
   logic [23:0] keep;
   logic known;
   logic in_range;
   logic data_side;

   // ----------------------------------------------------------------
   // request decode
   // ----------------------------------------------------------------
   assign priv_ok = (sys_req_el == crd_pkg::EL_TOP); // RULE_01
   assign take_write = sys_req_valid && sys_req_write && priv_ok &&
      (state_q == crd_pkg::CRD_IDLE);
   assign code = select_q[31:crd_pkg::SEL_CODE_LSB]; // RULE_03

   always_comb
   begin
      keep = 24'h000000;
      known = 1'b1;
      data_side = 1'b0;
      unique case (code) // RULE_20
         crd_pkg::CODE_DTAG:
         begin
            keep = crd_pkg::KEEP_DTAG;
            data_side = 1'b1;
         end
         crd_pkg::CODE_DDATA:
         begin
            keep = crd_pkg::KEEP_DDATA;
            data_side = 1'b1;
         end
         crd_pkg::CODE_DTLB:
         begin
            keep = crd_pkg::KEEP_DTLB;
            data_side = 1'b1;
         end
         crd_pkg::CODE_ITLB: keep = crd_pkg::KEEP_ITLB;
         crd_pkg::CODE_BRANCH_PREDICTION_QUEUE: keep = crd_pkg::KEEP_BRANCH_PREDICTION_QUEUE;
         crd_pkg::CODE_GHB: keep = crd_pkg::KEEP_GHB;
         default: known = 1'b0;
      endcase
   end

   // entries 48 and up do not exist
   assign in_range = (code != crd_pkg::CODE_DTLB) ||
      ({2'b00, select_q[5:0]} < crd_pkg::TLB_ENTRIES); // RULE_07

   // ----------------------------------------------------------------
   // selection register and fetch sequence
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         select_q <= crd_pkg::SELECT_RESET;
      else if (take_write)
         select_q <= sys_req_wdata; // RULE_01
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         state_q <= crd_pkg::CRD_IDLE;
      else
      begin
         unique case (state_q)
            crd_pkg::CRD_IDLE:
               if (take_write)
                  state_q <= crd_pkg::CRD_REQ;
            crd_pkg::CRD_REQ:
               if (known && in_range)
                  state_q <= crd_pkg::CRD_WAIT;
               else
                  state_q <= crd_pkg::CRD_IDLE;
            crd_pkg::CRD_WAIT:
               if (arr_rsp_valid)
                  state_q <= crd_pkg::CRD_IDLE;
            default: state_q <= crd_pkg::CRD_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         arr_req_valid <= 1'b0;
         arr_req_code <= 8'h00;
         arr_req_way <= 2'h0;
         arr_req_copy <= 1'b0;
         arr_req_bank <= 2'h0;
         arr_req_loc <= 24'h000000;
      end
      else
      begin
         arr_req_valid <= (state_q == crd_pkg::CRD_REQ) && known &&
            in_range;
         arr_req_code <= code;
         // way is set-associative placement within four ways
         arr_req_way <= (code == crd_pkg::CODE_DTAG ||
            code == crd_pkg::CODE_DDATA) ?
            select_q[crd_pkg::SEL_WAY_LSB +: 2] : 2'h0; // RULE_04
         arr_req_copy <= (code == crd_pkg::CODE_DTAG) &&
            select_q[crd_pkg::SEL_COPY_BIT]; // RULE_05
         arr_req_bank <= (code == crd_pkg::CODE_DDATA) ?
            select_q[crd_pkg::SEL_BANK_LSB +: 2] : 2'h0; // RULE_06
         arr_req_loc <= select_q[23:0] & keep; // RULE_20
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         sel_busy <= 1'b0;
      else
         sel_busy <= take_write || (state_q == crd_pkg::CRD_REQ &&
            known && in_range) ||
            (state_q == crd_pkg::CRD_WAIT && !arr_rsp_valid); // RULE_21
   end

   always_ff @(posedge core_clk)
   begin
      protect_q <= cache_protect_present;
      page_hw_attribute_opt_q <= page_attr_build_option;
   end

   // ----------------------------------------------------------------
   // packing of the returned entry
   // ----------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         ipack[i] = 64'h0; // RULE_20
         dpack[i] = 64'h0;
      end
      unique case (code)
         crd_pkg::CODE_DTAG:
         begin
            dpack[0][crd_pkg::DT_O_ECC +: 7] =
               arr_rsp_data[crd_pkg::DT_R_ECC +: 7]; // RULE_08
            dpack[0][crd_pkg::DT_O_NS] = arr_rsp_data[crd_pkg::DT_R_NS];
            dpack[0][crd_pkg::DT_O_PA +: 36] =
               arr_rsp_data[crd_pkg::DT_R_PA +: 36];
            dpack[0][crd_pkg::DT_O_HINT] =
               arr_rsp_data[crd_pkg::DT_R_HINT]; // RULE_09
            dpack[0][crd_pkg::DT_O_STATE +: 2] =
               arr_rsp_data[crd_pkg::DT_R_STATE +: 2];
         end
         crd_pkg::CODE_DDATA:
         begin
            dpack[0] = arr_rsp_data[63:0]; // RULE_10
            dpack[1] = arr_rsp_data[127:64];
            if (protect_q)
               dpack[2][31:0] = arr_rsp_data[crd_pkg::DD_R_CHK +: 32]; // RULE_11
         end
         crd_pkg::CODE_DTLB:
         begin
            dpack[0][crd_pkg::TL_O_VA +: 2] =
               arr_rsp_data[crd_pkg::TL_R_VA +: 2]; // RULE_13
            dpack[0][crd_pkg::TL_O_OSH] = arr_rsp_data[crd_pkg::TL_R_OSH];
            dpack[0][crd_pkg::TL_O_ISH] = arr_rsp_data[crd_pkg::TL_R_ISH];
            dpack[0][crd_pkg::TL_O_ATTR +: 3] =
               arr_rsp_data[crd_pkg::TL_R_ATTR +: 3]; // RULE_12
            dpack[0][crd_pkg::TL_O_SIZE +: 3] =
               arr_rsp_data[crd_pkg::TL_R_SIZE +: 3];
            dpack[0][crd_pkg::TL_O_NS] = arr_rsp_data[crd_pkg::TL_R_NS];
            dpack[0][crd_pkg::TL_O_REGIME +: 2] =
               arr_rsp_data[crd_pkg::TL_R_REGIME +: 2];
            dpack[0][crd_pkg::TL_O_ASID +: 16] =
               arr_rsp_data[crd_pkg::TL_R_ASID +: 16]; // RULE_14
            dpack[0][crd_pkg::TL_O_VMID +: 16] =
               arr_rsp_data[crd_pkg::TL_R_VMID +: 16];
            dpack[0][crd_pkg::TL_O_VALID] =
               arr_rsp_data[crd_pkg::TL_R_VALID];
            dpack[1][crd_pkg::TL_O_PALO +: 29] =
               arr_rsp_data[crd_pkg::TL_R_PALO +: 29]; // RULE_15
            dpack[1][34:0] = arr_rsp_data[crd_pkg::TL_R_VAHI +: 35];
            dpack[2][6:0] = arr_rsp_data[crd_pkg::TL_R_PAHI +: 7];
            if (page_hw_attribute_opt_q)
               dpack[2][crd_pkg::TL_O_PAGE_HW_ATTRIBUTE +: 2] =
                  arr_rsp_data[crd_pkg::TL_R_PAGE_HW_ATTRIBUTE +: 2];
         end
         crd_pkg::CODE_ITLB:
         begin
            ipack[0][crd_pkg::IT_O_VA +: 5] =
               arr_rsp_data[crd_pkg::IT_R_VA +: 5]; // RULE_16
            if (page_hw_attribute_opt_q)
               ipack[0][crd_pkg::IT_O_PAGE_HW_ATTRIBUTE +: 2] =
                  arr_rsp_data[crd_pkg::IT_R_PAGE_HW_ATTRIBUTE +: 2];
            ipack[0][crd_pkg::IT_O_ATTR +: 3] =
               arr_rsp_data[crd_pkg::IT_R_ATTR +: 3]; // RULE_12
            ipack[0][crd_pkg::IT_O_SIZE +: 3] =
               arr_rsp_data[crd_pkg::IT_R_SIZE +: 3];
            ipack[1][crd_pkg::IT_O_PALO +: 32] =
               arr_rsp_data[crd_pkg::IT_R_PALO +: 32]; // RULE_17
            ipack[1][31:0] = arr_rsp_data[crd_pkg::IT_R_VAHI +: 32];
            ipack[2][crd_pkg::IT_O_NS] = arr_rsp_data[crd_pkg::IT_R_NS];
            ipack[2][3:0] = arr_rsp_data[crd_pkg::IT_R_PAHI +: 4];
         end
         crd_pkg::CODE_BRANCH_PREDICTION_QUEUE:
         begin
            ipack[0] = arr_rsp_data[63:0]; // RULE_18
            ipack[2][31:0] = arr_rsp_data[95:64];
         end
         crd_pkg::CODE_GHB:
         begin
            ipack[0] = arr_rsp_data[63:0]; // RULE_19
            ipack[1][17:0] = arr_rsp_data[81:64];
         end
         default:
         begin
            ipack[0] = 64'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // readout registers
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 3; g++)
   begin : g_readout
      always_ff @(posedge core_clk)
      begin
         if (rst)
         begin
            idata_q[g] <= crd_pkg::READOUT_RESET;
            ddata_q[g] <= crd_pkg::READOUT_RESET;
         end
         else if (state_q == crd_pkg::CRD_WAIT && arr_rsp_valid)
         begin
            if (data_side)
               ddata_q[g] <= dpack[g]; // RULE_02
            else
               idata_q[g] <= ipack[g];
         end
         else if (state_q == crd_pkg::CRD_REQ && !(known && in_range))
         begin
            idata_q[g] <= crd_pkg::READOUT_RESET; // RULE_20
            ddata_q[g] <= crd_pkg::READOUT_RESET;
         end
      end
   end

   // ----------------------------------------------------------------
   // system register answer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sys_rsp_valid <= 1'b0;
         sys_rsp_undef <= 1'b0;
         sys_rsp_rdata <= 64'h0;
      end
      else
      begin
         sys_rsp_valid <= sys_req_valid;
         sys_rsp_undef <= sys_req_valid && (!priv_ok ||
            (!sys_req_write && sys_req_reg > crd_pkg::REG_DDATA2)); // RULE_01
         sys_rsp_rdata <= 64'h0;
         if (sys_req_valid && !sys_req_write && priv_ok)
         begin
            unique case (sys_req_reg)
               crd_pkg::REG_IDATA0: sys_rsp_rdata <= idata_q[0]; // RULE_02
               crd_pkg::REG_IDATA1: sys_rsp_rdata <= idata_q[1];
               crd_pkg::REG_IDATA2: sys_rsp_rdata <= idata_q[2];
               crd_pkg::REG_DDATA0: sys_rsp_rdata <= ddata_q[0];
               crd_pkg::REG_DDATA1: sys_rsp_rdata <= ddata_q[1];
               crd_pkg::REG_DDATA2: sys_rsp_rdata <= ddata_q[2];
               default: sys_rsp_rdata <= 64'h0;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: sim/crd_readout_sva.sv
// crd_readout_sva: port checks for the debug readout block.
// assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module crd_readout_sva
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // system register access
   input wire logic sys_req_valid,
   input wire logic sys_req_write,
   input wire logic [2:0] sys_req_reg,
   input wire logic [1:0] sys_req_el,
   input wire logic [31:0] sys_req_wdata,
   input wire logic sys_rsp_valid,
   input wire logic sys_rsp_undef,
   input wire logic [63:0] sys_rsp_rdata,
   input wire logic sel_busy,
   // array fetch port
   input wire logic arr_req_valid,
   input wire logic [7:0] arr_req_code,
   input wire logic arr_req_copy,
   input wire logic [1:0] arr_req_bank,
   input wire logic [23:0] arr_req_loc
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   logic [31:0] sel_q;
   wire logic [7:0] code = sys_req_wdata[31:24];
   wire logic wr_ok = sys_req_valid && sys_req_write && sys_req_el == 2'h3
      && !sel_busy;
   wire logic bad_sel = !(code inside {8'h03, 8'h04, 8'h05, 8'h08, 8'h09,
      8'h0A}) || (code == 8'h0A && sys_req_wdata[5:0] >= 6'h30);

   // last accepted selection word
   always_ff @(posedge core_clk)
   begin
      if (rst)
         sel_q <= 32'h0;
      else if (wr_ok)
         sel_q <= sys_req_wdata;
   end

   a_rsp_one_later: assert property (sys_req_valid |=> sys_rsp_valid)
      else $error("no response one cycle after request");
   a_rsp_no_stray: assert property (!sys_req_valid |=> !sys_rsp_valid)
      else $error("response without request");
   a_low_el_undef: assert property (sys_req_valid && sys_req_el != 2'h3
      |=> sys_rsp_undef && sys_rsp_rdata == 64'h0)
      else $error("lower level access not refused");
   a_top_el_allowed: assert property (sys_req_valid && sys_req_el == 2'h3
      && (sys_req_write || sys_req_reg < 3'h6) |=> !sys_rsp_undef)
      else $error("top level access refused");
   a_write_busy: assert property (wr_ok |=> sel_busy)
      else $error("accepted write did not raise busy");
   a_tag_copy_fetch: assert property (wr_ok && code == 8'h08 |=> ##1
      arr_req_valid && arr_req_code == 8'h08 && arr_req_copy == sel_q[17])
      else $error("tag fetch wrong copy or missing");
   a_bank_fetch: assert property (wr_ok && code == 8'h09 |=> ##1
      arr_req_valid && arr_req_bank == sel_q[17:16]
      && arr_req_loc[15:14] == 2'h0)
      else $error("data fetch wrong bank");
   a_tlb_entry_range: assert property (arr_req_valid && arr_req_code == 8'h0A
      |-> arr_req_loc[5:0] < 6'h30 && arr_req_loc[23:6] == 18'h0)
      else $error("tlb fetch out of range");
   a_bad_sel_idle: assert property (wr_ok && bad_sel |=> ##1
      !sel_busy && !arr_req_valid)
      else $error("bad selection started a fetch");

   cover property (wr_ok && code == 8'h08);
   cover property (sys_rsp_undef);
   cover property (arr_req_valid && arr_req_code == 8'h0A);
endmodule

bind crd_readout crd_readout_sva chk_u
(
   .core_clk(core_clk), .rst(rst), .sys_req_valid(sys_req_valid),
   .sys_req_write(sys_req_write), .sys_req_reg(sys_req_reg),
   .sys_req_el(sys_req_el), .sys_req_wdata(sys_req_wdata),
   .sys_rsp_valid(sys_rsp_valid), .sys_rsp_undef(sys_rsp_undef),
   .sys_rsp_rdata(sys_rsp_rdata), .sel_busy(sel_busy),
   .arr_req_valid(arr_req_valid), .arr_req_code(arr_req_code),
   .arr_req_copy(arr_req_copy), .arr_req_bank(arr_req_bank),
   .arr_req_loc(arr_req_loc)
);

`default_nettype wire

// File: sim/tb_cache_ram_debug_readout.sv
// tb_cache_ram_debug_readout: directed bench for crd_readout.
// assumes the bench plays the array port, driving on falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb_cache_ram_debug_readout;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cache_protect_present = 1'b1;
   logic page_attr_build_option = 1'b1;
   logic sys_req_valid = 1'b0;
   logic sys_req_write = 1'b0;
   logic [2:0] sys_req_reg = 3'h0;
   logic [1:0] sys_req_el = 2'h0;
   logic [31:0] sys_req_wdata = 32'h0;
   logic arr_rsp_valid = 1'b0;
   logic [159:0] arr_rsp_data = '1;
   logic sys_rsp_valid, sys_rsp_undef, sel_busy, arr_req_valid, arr_req_copy;
   logic [63:0] sys_rsp_rdata, rd_v, last_d0;
   logic [7:0] arr_req_code;
   logic [1:0] arr_req_way, arr_req_bank;
   logic [23:0] arr_req_loc;
   logic [159:0] raw;
   logic u_v;
   int failures = 0;
   int n_compared = 0;

   always #4 core_clk = ~core_clk;

   crd_readout dut_u
   (
      .core_clk(core_clk), .rst(rst),
      .cache_protect_present(cache_protect_present),
      .page_attr_build_option(page_attr_build_option),
      .sys_req_valid(sys_req_valid), .sys_req_write(sys_req_write),
      .sys_req_reg(sys_req_reg), .sys_req_el(sys_req_el),
      .sys_req_wdata(sys_req_wdata), .sys_rsp_valid(sys_rsp_valid),
      .sys_rsp_undef(sys_rsp_undef), .sys_rsp_rdata(sys_rsp_rdata),
      .sel_busy(sel_busy), .arr_req_valid(arr_req_valid),
      .arr_req_code(arr_req_code), .arr_req_way(arr_req_way),
      .arr_req_copy(arr_req_copy), .arr_req_bank(arr_req_bank),
      .arr_req_loc(arr_req_loc), .arr_rsp_valid(arr_rsp_valid),
      .arr_rsp_data(arr_rsp_data)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic sreq(input logic w, input logic [2:0] r,
      input logic [1:0] el, input logic [31:0] wd);
      @(negedge core_clk);
      sys_req_valid = 1'b1;
      sys_req_write = w;
      sys_req_reg = r;
      sys_req_el = el;
      sys_req_wdata = wd;
      @(negedge core_clk);
      sys_req_valid = 1'b0;
      chk("rsp_valid", 64'h1, {63'h0, sys_rsp_valid});
      rd_v = sys_rsp_rdata;
      u_v = sys_rsp_undef;
   endtask

   task automatic rdc(input logic [2:0] r, input logic [63:0] e,
      input string nm);
      sreq(1'b0, r, 2'h3, 32'h0);
      chk("read_undef", 64'h0, {63'h0, u_v});
      chk(nm, e, rd_v);
   endtask

   // write select, check the fetch, answer after dly cycles
   task automatic fetch(input logic [31:0] sel, input logic [23:0] loc,
      input int dly, input logic mid);
      int n;
      logic [2:0] cb;
      logic [1:0] wy;
      n = 0;
      wy = (sel[31:24] == 8'h08 || sel[31:24] == 8'h09) ? sel[19:18] : 2'h0;
      cb = {sel[31:24] == 8'h08 && sel[17],
         sel[31:24] == 8'h09 ? sel[17:16] : 2'h0};
      sreq(1'b1, 3'h0, 2'h3, sel);
      while (arr_req_valid !== 1'b1 && n < 8)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("req_code", {56'h0, sel[31:24]}, {56'h0, arr_req_code});
      chk("req_loc", {40'h0, loc}, {40'h0, arr_req_loc});
      chk("req_cb", {61'h0, cb}, {61'h0, arr_req_copy, arr_req_bank});
      chk("req_way", {62'h0, wy}, {62'h0, arr_req_way});
      if (mid)
      begin
         sreq(1'b1, 3'h0, 2'h3, 32'h08FF_FFFF);
         chk("busy_write_undef", 64'h0, {63'h0, u_v});
      end
      repeat (dly) @(negedge core_clk);
      arr_rsp_valid = 1'b1;
      arr_rsp_data = raw;
      @(negedge core_clk);
      arr_rsp_valid = 1'b0;
      arr_rsp_data = ~raw;
      chk("busy_done", 64'h0, {63'h0, sel_busy});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_priv();
      for (int r = 0; r < 6; r++)
         rdc(3'(r), 64'h0, "reset_readout");
      for (int e = 0; e < 3; e++)
      begin
         sreq(1'b1, 3'h0, 2'(e), 32'h08FF_FFFF);
         chk("low_write_undef", 64'h1, {63'h0, u_v});
         chk("low_write_busy", 64'h0, {63'h0, sel_busy});
         sreq(1'b0, 3'h3, 2'(e), 32'h0);
         chk("low_read_undef", 64'h1, {63'h0, u_v});
      end
      for (int r = 6; r < 8; r++)
      begin
         sreq(1'b0, 3'(r), 2'h3, 32'h0);
         chk("bad_reg_undef", 64'h1, {63'h0, u_v});
      end
   endtask

   task automatic t_dtag();
      logic [63:0] e;
      for (int s = 0; s < 4; s++)
      begin
         raw = '1;
         raw[46:0] = {7'h5A, 1'b1, 36'h9_8765_4321, s[0], 2'(s)};
         e = {15'h0, 7'h5A, 1'b1, 36'h9_8765_4321, 2'h0, s[0], 2'(s)};
         fetch({14'h023F, s[0], 17'h1FFFF}, {6'h03, s[0], 17'h03FC0}, 0, 0);
         rdc(3'h3, e, "dtag_d0");
         rdc(3'h4, 64'h0, "dtag_d1");
         rdc(3'h5, 64'h0, "dtag_d2");
      end
   endtask

   task automatic t_ddata();
      for (int p = 1; p >= 0; p--)
      begin
         cache_protect_present = p[0];
         raw = {32'hA53C_817E, 128'h4444_4444_3333_3333_2222_2222_1111_1111};
         fetch({15'h04FF, p[0], 16'hFFFF}, {7'h07, p[0], 16'h3FC0}, 2, 0);
         rdc(3'h3, 64'h2222_2222_1111_1111, "ddata_d0");
         rdc(3'h4, 64'h4444_4444_3333_3333, "ddata_d1");
         rdc(3'h5, p ? 64'hA53C_817E : 64'h0, "ddata_d2");
      end
   endtask

   task automatic t_dtlb();
      logic [63:0] e;
      for (int a = 0; a < 8; a++)
      begin
         page_attr_build_option = a < 7;
         raw = '1;
         raw[118:0] = {2'h2, 7'h55, 35'h5_1234_5678, 29'h0ABC_DEF1, 1'b1,
            16'h1234, 16'hBEEF, 2'(a), 1'b1, 3'(7 - a), 3'(a), 2'h1, 2'h2};
         e = {2'h2, 5'h2, 4'h0, 3'(a), 11'h0, 3'(7 - a), 1'b1, 2'(a),
            16'hBEEF, 16'h1234, 1'b1};
         fetch(32'h0AFF_FFEF, 24'h00002F, a, 0);
         rdc(3'h3, e, "dtlb_d0");
         rdc(3'h4, {29'h0ABC_DEF1, 35'h5_1234_5678}, "dtlb_d1");
         rdc(3'h5, {55'h0, a < 7 ? 2'h2 : 2'h0, 7'h55}, "dtlb_d2");
      end
      last_d0 = e;
   endtask

   task automatic t_itlb();
      page_attr_build_option = 1'b1;
      raw = '1;
      raw[81:0] = {4'hA, 1'b1, 64'h1357_9BDF_CAFE_F00D, 6'h2E, 2'h1, 5'h15};
      fetch(32'h04FF_FF2E, 24'h00002E, 1, 0);
      rdc(3'h0, {5'h15, 2'h1, 1'b0, 3'h6, 3'h5, 50'h0}, "itlb_i0");
      rdc(3'h1, 64'hCAFE_F00D_1357_9BDF, "itlb_i1");
      rdc(3'h2, {59'h0, 1'b1, 4'hA}, "itlb_i2");
      rdc(3'h3, last_d0, "itlb_keeps_d0");
   endtask

   task automatic t_branch_prediction_queue_ghb();
      raw = '1;
      raw[95:0] = 96'hFEDC_BA98_7654_3210_0F1E_2D3C;
      fetch(32'h05FF_FFFF, 24'h0003F0, 0, 0);
      rdc(3'h0, 64'h7654_3210_0F1E_2D3C, "branch_prediction_queue_i0");
      rdc(3'h1, 64'h0, "branch_prediction_queue_i1");
      rdc(3'h2, 64'hFEDC_BA98, "branch_prediction_queue_i2");
      raw[81:0] = {18'h2_5A5A, 64'h0123_4567_89AB_CDEF};
      fetch(32'h03FF_FFFF, 24'h003FF0, 3, 1);
      rdc(3'h0, 64'h0123_4567_89AB_CDEF, "ghb_i0");
      rdc(3'h1, 64'h2_5A5A, "ghb_i1");
      rdc(3'h2, 64'h0, "ghb_i2");
   endtask

   task automatic t_bad();
      for (int k = 0; k < 2; k++)
      begin
         sreq(1'b1, 3'h0, 2'h3, k ? 32'h0A00_0030 : 32'h0700_0000);
         @(negedge core_clk);
         chk("bad_no_fetch", 64'h0, {62'h0, arr_req_valid, sel_busy});
         rdc(3'h3, 64'h0, "bad_clears_d0");
         rdc(3'h0, 64'h0, "bad_clears_i0");
      end
   endtask

   task automatic summarize();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      t_priv();
      t_dtag();
      t_ddata();
      t_dtlb();
      t_itlb();
      t_branch_prediction_queue_ghb();
      t_bad();
      summarize();
   end

   initial
   begin
      #20000;
      failures++;
      summarize();
   end
endmodule

`default_nettype wire
